/* src/keystream_pkg.sv */
// Shared constants and types for the counter-mode keystream generator
package keystream_pkg;

  // ----------------------------------------------------------------------------
  // Block cipher geometry
  // ----------------------------------------------------------------------------
  localparam int unsigned AES_BITS       = 128;
  localparam int unsigned KEY_MAX_BITS   = 128;
  localparam int unsigned IV_MAX_BITS    = 64;
  localparam int unsigned CTR_BITS       = 64;
  localparam logic [3:0]  AES_FIRST_RND  = 4'h1;
  localparam logic [3:0]  AES_LAST_RND   = 4'ha;
  localparam logic [7:0]  RCON_INIT      = 8'h01;
  localparam logic [7:0]  GF_POLY        = 8'h1b;
  localparam logic [7:0]  SBOX_CONST     = 8'h63;

  // ----------------------------------------------------------------------------
  // Sequence limits and widths
  // ----------------------------------------------------------------------------
  localparam int unsigned KS_MAX_LEN     = 4840;
  localparam int unsigned LEN_W          = 13;
  localparam int unsigned BLK_W          = 6;
  localparam int unsigned BLK_SHIFT      = 7;
  localparam int unsigned KEY_LEN_W      = 8;
  localparam int unsigned IV_LEN_W       = 7;
  localparam int unsigned BIT_IDX_W      = 7;
  localparam int unsigned LEGACY_BITS    = 64;
  localparam int unsigned TAG_BITS       = 32;
  localparam int unsigned FIFO_WIDTH     = 1;
  localparam int unsigned FIFO_DEPTH     = 8;

  // ----------------------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_ROUND = 4'b0010,
    ST_EMIT  = 4'b0100,
    ST_FIN   = 4'b1000
  } gen_state_t;

endpackage : keystream_pkg

/* src/bit_fifo.sv */
// Small flop-based FIFO with a registered output stage
`timescale 1ns/100ps
`default_nettype none
module bit_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i,
  output logic                  empty_o
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
    logic                        ovld;
    logic [WIDTH-1:0]            odat;
  } fifo_t;

  fifo_t fifo_ff;
  fifo_t nxt_fifo;
  logic  push;
  logic  pop;

  // Ready depends only on the fill level, so the source sees a clean stall
  assign in_ready_o  = (fifo_ff.cnt != CNT_FULL);
  assign out_valid_o = fifo_ff.ovld;
  assign out_data_o  = fifo_ff.odat;
  assign empty_o     = (fifo_ff.cnt == '0) && !fifo_ff.ovld;

  always_comb begin
    nxt_fifo = fifo_ff;
    push     = in_valid_i && (fifo_ff.cnt != CNT_FULL);
    pop      = (fifo_ff.cnt != '0) && (!fifo_ff.ovld || out_ready_i);
    if (fifo_ff.ovld && out_ready_i) begin
      nxt_fifo.ovld = 1'b0;
    end
    if (pop) begin
      nxt_fifo.odat = fifo_ff.mem[fifo_ff.rd];
      nxt_fifo.ovld = 1'b1;
      nxt_fifo.rd   = (fifo_ff.rd == PTR_LAST) ? '0 : fifo_ff.rd + 1'b1;
    end
    if (push) begin
      nxt_fifo.mem[fifo_ff.wr] = in_data_i;
      nxt_fifo.wr              = (fifo_ff.wr == PTR_LAST) ? '0 : fifo_ff.wr + 1'b1;
    end
    if (push && !pop) begin
      nxt_fifo.cnt = fifo_ff.cnt + 1'b1;
    end else if (pop && !push) begin
      nxt_fifo.cnt = fifo_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fifo_ff <= '0;
    end else begin
      fifo_ff <= nxt_fifo;
    end
  end

endmodule : bit_fifo
`default_nettype wire

/* src/keystream_generator.sv */
// Counter-mode block cipher keystream generator with key mapping and key derivation
`timescale 1ns/100ps
`default_nettype none
module keystream_generator
  import keystream_pkg::*;
#(
  parameter int unsigned MAX_LEN = KS_MAX_LEN,
  parameter int unsigned DEPTH   = FIFO_DEPTH
) (
  input  wire logic                 CLK_I,
  input  wire logic                 ARST_N_I,
  input  wire logic [0:127]         DERIVED_SESSION_KEY_I,
  input  wire logic [KEY_LEN_W-1:0] KEY_LEN_I,
  input  wire logic [0:63]          INIT_VECTOR_I,
  input  wire logic [IV_LEN_W-1:0]  IV_LEN_I,
  input  wire logic [LEN_W-1:0]     KS_LEN_I,
  input  wire logic                 START_I,
  input  wire logic [0:127]         DERIVE_INPUT_I,
  input  wire logic                 DERIVE_START_I,
  output logic                      KEYSTREAM_BITS_O,
  output logic                      KS_VALID_O,
  input  wire logic                 KS_READY_I,
  output logic                      BUSY_O,
  output logic                      DONE_O,
  output logic [0:31]               AUTH_TAG_O,
  output logic [0:127]              DERIVED_KEY_O,
  output logic [0:63]               LEGACY_CIPHER_KEY_O
);

  // ----------------------------------------------------------------------------
  // Field arithmetic and cipher round helpers
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] xtime(input logic [7:0] a);
    xtime = {a[6:0], 1'b0} ^ (a[7] ? GF_POLY : 8'h00);
  endfunction : xtime

  function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] acc;
    logic [7:0] sh;
    acc = 8'h00;
    sh  = a;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        acc = acc ^ sh;
      end
      sh = xtime(sh);
    end
    gf_mul = acc;
  endfunction : gf_mul

  // The substitution box is computed rather than tabulated: inverse as x^254,
  // then the affine map. Costs area but keeps the design free of a 256-entry table.
  function automatic logic [7:0] sbox(input logic [7:0] x);
    logic [7:0] sq;
    logic [7:0] inv;
    sq  = x;
    inv = 8'h01;
    for (int i = 1; i < 8; i++) begin
      sq  = gf_mul(sq, sq);
      inv = gf_mul(inv, sq);
    end
    sbox = inv ^ {inv[6:0], inv[7]} ^ {inv[5:0], inv[7:6]} ^ {inv[4:0], inv[7:5]}
         ^ {inv[3:0], inv[7:4]} ^ SBOX_CONST;
  endfunction : sbox

  function automatic logic [127:0] next_round_key(input logic [127:0] rk, input logic [7:0] rc);
    logic [31:0] w0;
    logic [31:0] w1;
    logic [31:0] w2;
    logic [31:0] w3;
    logic [31:0] t;
    w0 = rk[127:96];
    w1 = rk[95:64];
    w2 = rk[63:32];
    w3 = rk[31:0];
    t  = {sbox(w3[23:16]) ^ rc, sbox(w3[15:8]), sbox(w3[7:0]), sbox(w3[31:24])};
    w0 = w0 ^ t;
    w1 = w1 ^ w0;
    w2 = w2 ^ w1;
    w3 = w3 ^ w2;
    next_round_key = {w0, w1, w2, w3};
  endfunction : next_round_key

  // Byte k of the block sits at [127-8k -: 8]; column c holds bytes 4c..4c+3
  function automatic logic [127:0] cipher_round(input logic [127:0] s, input logic last);
    logic [7:0]   b [16];
    logic [7:0]   h [16];
    logic [127:0] o;
    for (int k = 0; k < 16; k++) begin
      b[k] = s[127-8*k -: 8];
    end
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        h[4*c+r] = sbox(b[4*((c+r)%4)+r]);
      end
    end
    for (int c = 0; c < 4; c++) begin
      if (last) begin
        for (int r = 0; r < 4; r++) begin
          o[127-8*(4*c+r) -: 8] = h[4*c+r];
        end
      end else begin
        for (int r = 0; r < 4; r++) begin
          o[127-8*(4*c+r) -: 8] = xtime(h[4*c+r]) ^ xtime(h[4*c+(r+1)%4]) ^ h[4*c+(r+1)%4]
                                ^ h[4*c+(r+2)%4] ^ h[4*c+(r+3)%4];
        end
      end
    end
    cipher_round = o;
  endfunction : cipher_round

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  typedef struct packed {
    gen_state_t           st;
    logic                 derive;
    logic                 pass2;
    logic [127:0]         key;
    logic [63:0]          ctr_hi;
    logic [127:0]         blk;
    logic [127:0]         rk;
    logic [3:0]           rnd;
    logic [7:0]           rcon;
    logic [127:0]         ct;
    logic [BIT_IDX_W-1:0] bit_idx;
    logic [LEN_W-1:0]     remain;
    logic [BLK_W-1:0]     idx;
    logic [BLK_W-1:0]     blocks;
    logic                 busy;
    logic                 done;
    logic [31:0]          tag;
    logic [127:0]         dkey;
    logic [63:0]          legacy;
  } gen_t;

  gen_t             gen_ff;
  gen_t             nxt_gen;
  logic             fifo_in_ready;
  logic             fifo_empty;
  logic             push_valid;
  logic [127:0]     round_out;
  logic [127:0]     next_rk;
  logic [LEN_W-1:0] len_clamped;
  logic [127:0]     key_padded;
  logic [63:0]      iv_placed;
  logic             emit_bit;

  localparam logic [LEN_W-1:0]     LEN_LIMIT  = LEN_W'(MAX_LEN);
  localparam logic [LEN_W-1:0]     BLK_ROUND  = LEN_W'(AES_BITS - 1);
  localparam logic [BIT_IDX_W-1:0] BIT_LAST   = BIT_IDX_W'(AES_BITS - 1);
  localparam logic [LEN_W-1:0]     ONE_LEFT   = LEN_W'(1);

  // ----------------------------------------------------------------------------
  // Input mapping
  // ----------------------------------------------------------------------------
  always_comb begin
    // Session key feeds the cipher key unchanged; only the length mask applies
    for (int i = 0; i < KEY_MAX_BITS; i++) begin
      key_padded[127-i] = DERIVED_SESSION_KEY_I[i] && (KEY_LEN_W'(i) < KEY_LEN_I);
    end
    // Vector bit i lands on counter bit i, i.e. block bit 64+i here
    for (int i = 0; i < IV_MAX_BITS; i++) begin
      iv_placed[i] = INIT_VECTOR_I[i] && (IV_LEN_W'(i) < IV_LEN_I);
    end
    // Lengths past the system limit are clamped rather than refused, so an
    // oversized request still ends with a completion pulse
    len_clamped = (KS_LEN_I > LEN_LIMIT) ? LEN_LIMIT : KS_LEN_I;
  end

  assign round_out  = cipher_round(gen_ff.blk, gen_ff.rnd == AES_LAST_RND) ^ next_rk;
  assign next_rk    = next_round_key(gen_ff.rk, gen_ff.rcon);
  assign push_valid = (gen_ff.st == ST_EMIT);

  // ----------------------------------------------------------------------------
  // Bit selection
  // ----------------------------------------------------------------------------
  // Ciphertext bit 0 is the top bit of the block register, so the emit index
  // counts up and selects from the top down; a short final block simply stops early
  assign emit_bit = gen_ff.ct[BIT_LAST - gen_ff.bit_idx];

  // ----------------------------------------------------------------------------
  // Controller
  // ----------------------------------------------------------------------------
  // One round per clock: a block costs ten cycles, the initial key addition is
  // folded into the load. Keystream start to first valid bit is thirteen cycles:
  // one to load, ten rounds, one into the buffer, one into its output register.
  // A derivation runs two blocks back to back and completes twenty-two cycles
  // after it is taken. Round keys are rebuilt from the stored cipher key for
  // every block, trading a little logic per round for not keeping ten keys.
  // Starts are only looked at in idle; anything raised while busy is dropped.
  always_comb begin
    nxt_gen      = gen_ff;
    nxt_gen.done = 1'b0;
    unique case (gen_ff.st)
      ST_IDLE: begin
        // Derivation wins when both starts arrive in the same cycle
        if (DERIVE_START_I) begin
          nxt_gen.derive = 1'b1;
          nxt_gen.pass2  = 1'b0;
          nxt_gen.key    = DERIVED_SESSION_KEY_I;
          nxt_gen.blk    = DERIVE_INPUT_I ^ DERIVED_SESSION_KEY_I;
          nxt_gen.rk     = DERIVED_SESSION_KEY_I;
          nxt_gen.rnd    = AES_FIRST_RND;
          nxt_gen.rcon   = RCON_INIT;
          nxt_gen.busy   = 1'b1;
          nxt_gen.st     = ST_ROUND;
        end else if (START_I) begin
          nxt_gen.derive = 1'b0;
          nxt_gen.key    = key_padded;
          nxt_gen.ctr_hi = iv_placed;
          nxt_gen.remain = len_clamped;
          nxt_gen.blocks = BLK_W'((len_clamped + BLK_ROUND) >> BLK_SHIFT);
          nxt_gen.idx    = '0;
          // Counter block of index 0: vector half above, index half below
          nxt_gen.blk    = {iv_placed, 64'h0} ^ key_padded;
          nxt_gen.rk     = key_padded;
          nxt_gen.rnd    = AES_FIRST_RND;
          nxt_gen.rcon   = RCON_INIT;
          nxt_gen.busy   = 1'b1;
          // A zero length produces no block and completes at once
          nxt_gen.st     = (len_clamped == '0) ? ST_FIN : ST_ROUND;
        end
      end
      ST_ROUND: begin
        nxt_gen.rk   = next_rk;
        nxt_gen.rcon = xtime(gen_ff.rcon);
        nxt_gen.rnd  = gen_ff.rnd + 1'b1;
        nxt_gen.blk  = round_out;
        if (gen_ff.rnd == AES_LAST_RND) begin
          nxt_gen.ct      = round_out;
          nxt_gen.bit_idx = '0;
          if (!gen_ff.derive) begin
            nxt_gen.st = ST_EMIT;
          end else if (!gen_ff.pass2) begin
            nxt_gen.tag   = round_out[127:96];
            nxt_gen.pass2 = 1'b1;
            nxt_gen.blk   = {round_out[127:1], ~round_out[0]} ^ gen_ff.key;
            nxt_gen.rk    = gen_ff.key;
            nxt_gen.rnd   = AES_FIRST_RND;
            nxt_gen.rcon  = RCON_INIT;
          end else begin
            nxt_gen.dkey = round_out;
            // Legacy key: first 64 bits, bytes reversed; the legacy path never sees more
            for (int i = 0; i < LEGACY_BITS / 8; i++) begin
              nxt_gen.legacy[63-8*i -: 8] = round_out[127-8*(7-i) -: 8];
            end
            nxt_gen.st = ST_FIN;
          end
        end
      end
      ST_EMIT: begin
        // Stalls here whenever the FIFO is full, so the consumer sets the pace
        if (fifo_in_ready) begin
          nxt_gen.bit_idx = gen_ff.bit_idx + 1'b1;
          nxt_gen.remain  = gen_ff.remain - 1'b1;
          if (gen_ff.remain == ONE_LEFT) begin
            // Rest of a short final block is simply never pushed
            nxt_gen.st = ST_FIN;
          end else if (gen_ff.bit_idx == BIT_LAST && (gen_ff.idx + 1'b1) < gen_ff.blocks) begin
            // Next block only while the block count says one is still owed
            nxt_gen.idx  = gen_ff.idx + 1'b1;
            nxt_gen.blk  = {gen_ff.ctr_hi, CTR_BITS'(gen_ff.idx + 1'b1)} ^ gen_ff.key;
            nxt_gen.rk   = gen_ff.key;
            nxt_gen.rnd  = AES_FIRST_RND;
            nxt_gen.rcon = RCON_INIT;
            nxt_gen.st   = ST_ROUND;
          end
        end
      end
      ST_FIN: begin
        // Completion waits for the FIFO to drain so it marks true delivery
        if (fifo_empty) begin
          nxt_gen.busy = 1'b0;
          nxt_gen.done = 1'b1;
          nxt_gen.st   = ST_IDLE;
        end
      end
      default: begin
        nxt_gen.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gen_ff    <= '0;
      gen_ff.st <= ST_IDLE;
    end else begin
      gen_ff <= nxt_gen;
    end
  end

  // ----------------------------------------------------------------------------
  // Output buffer
  // ----------------------------------------------------------------------------
  bit_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .arst_n_i    (ARST_N_I),
    .in_valid_i  (push_valid),
    .in_data_i   (emit_bit),
    .in_ready_o  (fifo_in_ready),
    .out_valid_o (KS_VALID_O),
    .out_data_o  (KEYSTREAM_BITS_O),
    .out_ready_i (KS_READY_I),
    .empty_o     (fifo_empty)
  );

  // ----------------------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------------------
  // All of these come straight from the state register, never from decode
  assign BUSY_O              = gen_ff.busy;
  assign DONE_O              = gen_ff.done;
  assign AUTH_TAG_O          = gen_ff.tag;
  assign DERIVED_KEY_O       = gen_ff.dkey;
  assign LEGACY_CIPHER_KEY_O = gen_ff.legacy;

endmodule : keystream_generator
`default_nettype wire

/* verif/keystream_generator_props.sv */
// Concurrent checks on the keystream generator ports
`timescale 1ns/100ps
`default_nettype none
module keystream_generator_props
  import keystream_pkg::*;
(
  input wire logic             CLK_I,
  input wire logic             ARST_N_I,
  input wire logic             START_I,
  input wire logic             DERIVE_START_I,
  input wire logic [LEN_W-1:0] KS_LEN_I,
  input wire logic             KEYSTREAM_BITS_O,
  input wire logic             KS_VALID_O,
  input wire logic             KS_READY_I,
  input wire logic             BUSY_O,
  input wire logic             DONE_O,
  input wire logic [0:127]     DERIVED_KEY_O,
  input wire logic [0:63]      LEGACY_CIPHER_KEY_O
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  logic ks_take;
  assign ks_take = START_I && !DERIVE_START_I && !BUSY_O;
  a_valid_hold: assert property (KS_VALID_O && !KS_READY_I |=> KS_VALID_O && $stable(KEYSTREAM_BITS_O))
    else $error("keystream bit dropped before it was taken");
  a_done_pulse: assert property (DONE_O |=> !DONE_O)
    else $error("completion longer than one cycle");
  a_done_ends_busy: assert property (DONE_O |-> !BUSY_O && $past(BUSY_O))
    else $error("completion without a busy phase");
  a_start_busy: assert property ((START_I || DERIVE_START_I) && !BUSY_O |=> BUSY_O)
    else $error("start not taken in idle");
  a_valid_busy: assert property (KS_VALID_O |-> BUSY_O)
    else $error("keystream valid outside a sequence");
  a_first_bit: assert property (ks_take && KS_LEN_I != 0 |-> ##[11:13] KS_VALID_O)
    else $error("first keystream bit late");
  a_len_zero: assert property (ks_take && KS_LEN_I == 0 |-> !KS_VALID_O [*3] ##0 DONE_O)
    else $error("empty sequence not finished in two cycles");
  a_derive_time: assert property (DERIVE_START_I && !BUSY_O |-> ##22 DONE_O)
    else $error("derivation not finished in time");
  a_legacy_map: assert property (LEGACY_CIPHER_KEY_O == {<<8{DERIVED_KEY_O[0:63]}})
    else $error("legacy key bytes not reversed");
  c_stall: cover property (KS_VALID_O && !KS_READY_I ##1 KS_READY_I);
  c_derive: cover property (DERIVE_START_I && !BUSY_O ##22 DONE_O);
  c_empty: cover property (ks_take && KS_LEN_I == 0);
endmodule : keystream_generator_props
bind keystream_generator keystream_generator_props i_keystream_generator_props (
  .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .START_I(START_I), .DERIVE_START_I(DERIVE_START_I),
  .KS_LEN_I(KS_LEN_I), .KEYSTREAM_BITS_O(KEYSTREAM_BITS_O), .KS_VALID_O(KS_VALID_O),
  .KS_READY_I(KS_READY_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .DERIVED_KEY_O(DERIVED_KEY_O),
  .LEGACY_CIPHER_KEY_O(LEGACY_CIPHER_KEY_O));
`default_nettype wire

/* verif/ks_consumer.sv */
// Link-side consumer model that takes keystream bits with random stalls
`timescale 1ns/100ps
`default_nettype none
module ks_consumer (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic bit_i,
  input  wire logic valid_i,
  output logic      ready_o
);
  int   seed = 32'h1ae5;
  logic got[$];
  logic pt;
  logic ct;
  // Stalls about one cycle in four, so the generator must hold its bit across stalled edges
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ready_o <= 1'b0;
    end else begin
      if (valid_i && ready_o) begin
        // Encrypt an arbitrary data bit, then xor the same data bit back out to recover the key bit
        pt = 1'($random(seed));
        ct = pt ^ bit_i;
        got.push_back(ct ^ pt);
      end
      ready_o <= ($random(seed) % 4) != 0;
    end
  end
endmodule : ks_consumer
`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the keystream generator
`timescale 1ns/100ps
`default_nettype none
module tb;
  import keystream_pkg::*;
  logic CLK_I = 1'b0, ARST_N_I = 1'b0, START_I = 1'b0, DERIVE_START_I = 1'b0, KS_READY_I;
  logic [0:127] DERIVED_SESSION_KEY_I = '0, DERIVE_INPUT_I = '0;
  logic [0:63]  INIT_VECTOR_I = '0;
  logic [KEY_LEN_W-1:0] KEY_LEN_I = '0;
  logic [IV_LEN_W-1:0]  IV_LEN_I = '0;
  logic [LEN_W-1:0]     KS_LEN_I = '0;
  logic KEYSTREAM_BITS_O, KS_VALID_O, BUSY_O, DONE_O;
  logic [0:31]  AUTH_TAG_O;
  logic [0:127] DERIVED_KEY_O;
  logic [0:63]  LEGACY_CIPHER_KEY_O;
  int seed = 32'h1ae5;
  int err_total = 0;
  int tests_run = 0;
  logic [127:0] set11[6] = '{128'hb5d23e32b712b63e376360fb522cb1f5, 128'h1edd0ed98b5553477227ca871b8e652a,
    128'hdbb64a1ca85427beac153100e95f5c0e, 128'hf7904eae70cf0f20949d1c478835ee69,
    128'hd4cde775aecf7b7e65c000343088c020, 128'hd99c1529e6d636f77e328ddb0b3e21fd};
  always #2 CLK_I = ~CLK_I;
  keystream_generator i_keystream_generator (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
    .DERIVED_SESSION_KEY_I(DERIVED_SESSION_KEY_I), .KEY_LEN_I(KEY_LEN_I), .INIT_VECTOR_I(INIT_VECTOR_I),
    .IV_LEN_I(IV_LEN_I), .KS_LEN_I(KS_LEN_I), .START_I(START_I), .DERIVE_INPUT_I(DERIVE_INPUT_I),
    .DERIVE_START_I(DERIVE_START_I), .KEYSTREAM_BITS_O(KEYSTREAM_BITS_O), .KS_VALID_O(KS_VALID_O),
    .KS_READY_I(KS_READY_I), .BUSY_O(BUSY_O), .DONE_O(DONE_O), .AUTH_TAG_O(AUTH_TAG_O),
    .DERIVED_KEY_O(DERIVED_KEY_O), .LEGACY_CIPHER_KEY_O(LEGACY_CIPHER_KEY_O));
  ks_consumer i_ks_consumer (.clk_i(CLK_I), .arst_n_i(ARST_N_I), .bit_i(KEYSTREAM_BITS_O),
    .valid_i(KS_VALID_O), .ready_o(KS_READY_I));
  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic final_report;
    if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [127:0] e, input logic [127:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask : chk
  task automatic wait_done(input int lim);
    for (int i = 0; i <= lim; i++) begin
      @(negedge CLK_I);
      if (DONE_O === 1'b1) return;
    end
    chk("done timeout", 128'h1, 128'h0);
    final_report();
  endtask : wait_done
  function automatic logic [127:0] blk(input int s, input int w);
    logic [127:0] r;
    r = '0;
    for (int i = 0; i < w; i++) r = {r[126:0], i_ks_consumer.got[s+i]};
    return r;
  endfunction : blk
  // Second start is held while busy and must be ignored; inputs then change
  task automatic run_ks(input logic [0:127] k, input int m, input logic [63:0] v, input int n, input int lam);
    i_ks_consumer.got.delete();
    @(posedge CLK_I);
    DERIVED_SESSION_KEY_I <= k;
    KEY_LEN_I <= m[KEY_LEN_W-1:0];
    INIT_VECTOR_I <= {<<{v}};
    IV_LEN_I <= n[IV_LEN_W-1:0];
    KS_LEN_I <= lam[LEN_W-1:0];
    START_I <= 1'b1;
    repeat (2) @(posedge CLK_I);
    START_I <= 1'b0;
    DERIVED_SESSION_KEY_I <= {4{$random(seed)}};
    INIT_VECTOR_I <= {2{$random(seed)}};
    wait_done(20000);
    chk("bit count", 128'(lam), 128'(i_ks_consumer.got.size()));
  endtask : run_ks
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    logic [127:0] kg;
    int nblk;
    repeat (2) @(posedge CLK_I);
    ARST_N_I <= 1'b1;
    @(posedge CLK_I);
    DERIVED_SESSION_KEY_I <= 128'hc3d25e38117444ed4761f67adb94f80e;
    DERIVE_INPUT_I <= 128'h6ba2802b910ff33996bd2862c715fc88;
    DERIVE_START_I <= 1'b1;
    @(posedge CLK_I);
    DERIVE_START_I <= 1'b0;
    wait_done(40);
    chk("tag", 128'h4096c0af, 128'(AUTH_TAG_O));
    chk("derived key", 128'h01a063ba8e8a07cf063c6e233405f14e, DERIVED_KEY_O);
    chk("legacy key", 128'hcf078a8eba63a001, 128'(LEGACY_CIPHER_KEY_O));
    run_ks(128'h5e9d489c191661726b7232e6401d71f0, 128, 64'h03847f4f494a0677, 64, 720);
    nblk = (720 + 127) / 128;
    for (int j = 0; j < nblk; j++) begin
      if (j == nblk - 1) chk("last block", set11[j] >> 48, blk(128 * j, 720 - 128 * j));
      else chk("full block", set11[j], blk(128 * j, 128));
    end
    kg = {4{$random(seed)}};
    run_ks(128'h40805db2338000000000000000000000 | (kg >> 41), 41, 64'hffbf2f146ad6047e, 60, 4840);
    chk("padded block", 128'h0fcfcf7fe42734355ba01401e69ffaae, blk(4096, 128));
    run_ks(kg, 128, kg[63:0], 64, 0);
    final_report();
  end
endmodule : tb
`default_nettype wire
